//--- design/scds_buf.sv
/*
  Two-entry skid buffer on the received byte path.
  Assumes the source pushes only while ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module scds_buf
  import scds_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Filling side
  scds_stream_if.snk in_s,
  // Draining side
  scds_stream_if.src out_s
);
  logic skid_v_q; // Second entry holds a byte
  logic [7:0] skid_d_q; // Second entry data
  logic out_v_q; // Head entry holds a byte
  logic [7:0] out_d_q; // Head entry data
  logic take; // Incoming byte accepted
  logic head_free; // Head empties this cycle

  assign take = in_s.valid & ~skid_v_q;
  assign head_free = ~out_v_q | out_s.ready;
  assign in_s.ready = ~skid_v_q;
  assign out_s.valid = out_v_q;
  assign out_s.data = out_d_q;

  // Entry movement
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skid_v_q <= 1'b0;
      skid_d_q <= 8'h00;
      out_v_q <= 1'b0;
      out_d_q <= 8'h00;
    end else if (head_free) begin
      // Refill head, skid first to keep order
      if (skid_v_q) begin
        out_d_q <= skid_d_q;
        out_v_q <= 1'b1;
        skid_v_q <= take;
        if (take) begin
          skid_d_q <= in_s.data;
        end
      end else begin
        out_v_q <= take;
        if (take) begin
          out_d_q <= in_s.data;
        end
      end
    end else if (take) begin
      // Head stalled: park in skid
      skid_d_q <= in_s.data;
      skid_v_q <= 1'b1;
    end
  end

  buf_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    out_v_q && !out_s.ready |=> out_v_q && $stable(out_d_q))
    else $error("buffer head changed while stalled");
  buf_full_c: cover property (@(posedge sys_clk) disable iff (rst)
    skid_v_q && out_v_q);
endmodule : scds_buf
`default_nettype wire

//--- design/scds_pkg.sv
/*
  Constants for the serial command and data slave: instruction codes,
  mode register layout, pin indices and timing counts.
  Assumes a 40 MHz system clock and pins coming from another domain.
*/
package scds_pkg;
  // Instruction opcodes
  localparam logic [7:0] SCDS_INSTR_READ = 8'h03;
  localparam logic [7:0] SCDS_INSTR_WRITE = 8'h02;
  // Address of the locally held mode register
  localparam logic [7:0] SCDS_MODE_ADDR = 8'h00;
  // Mode register bit positions
  localparam int SCDS_BIT_NATIVE_PIN = 0;
  localparam int SCDS_BIT_SHARED = 1;
  localparam int SCDS_BIT_NEWMODE = 2;
  localparam int SCDS_BIT_LARGE_AREA = 3;
  localparam int SCDS_BIT_FALLING = 4;
  localparam int SCDS_BIT_LSB_FIRST = 5;
  // Mode register reset value: native pins and native framing
  localparam logic [15:0] SCDS_MODE_RESET = 16'h0005;
  // Pin indices in the synchroniser vector
  localparam int SCDS_PIN_SCK = 0;
  localparam int SCDS_PIN_SI = 1;
  localparam int SCDS_PIN_CS = 2;
  localparam int SCDS_PIN_SYNC = 3;
  localparam int SCDS_PIN_DATA_BIT_CLOCK = 4;
  localparam int SCDS_PIN_DATA_SERIAL_IN = 5;
  localparam int SCDS_PINS = 6;
  // Synchroniser reset levels match idle pins: selects and data high,
  // clocks low, so no false select or clock edge follows reset
  localparam logic [SCDS_PINS-1:0] SCDS_PIN_IDLE = 6'h2e;
  // Safety areas in bytes
  localparam logic [9:0] SCDS_AREA_SMALL = 10'h020;
  localparam logic [9:0] SCDS_AREA_LARGE = 10'h200;
  // Timing
  localparam int SCDS_CLK_NS = 25;
  localparam int SCDS_WR_LOW_NS = 200;
  localparam int SCDS_RD_LOW_NS = 50;
  localparam logic [3:0] SCDS_WR_LOW_CYC =
    4'((SCDS_WR_LOW_NS + SCDS_CLK_NS - 1) / SCDS_CLK_NS);
  localparam logic [3:0] SCDS_RD_LOW_CYC =
    4'((SCDS_RD_LOW_NS + SCDS_CLK_NS - 1) / SCDS_CLK_NS);
  // Command port states
  typedef enum logic [1:0] {
    SCDS_C_HDR, SCDS_C_WR, SCDS_C_RD, SCDS_C_SKIP
  } scds_cmd_t;
endpackage : scds_pkg

//--- design/scds_stream_if.sv
/*
  Byte stream carrier between the receiver and its buffer.
  Assumes one clock domain; valid and ready handshake.
*/
`timescale 1ns/1ps
`default_nettype none
interface scds_stream_if;
  logic valid; // Byte offered
  logic ready; // Byte can be taken
  logic [7:0] data; // Byte value
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : scds_stream_if
`default_nettype wire

//--- design/scds_top.sv
/*
  Serial command and data slave: command port frames, data port byte
  receiver in native, compatibility and passive modes, data request.
  Assumes pins from the host arrive unsynchronised; register reads of
  addresses other than the mode register are answered on reg_rdata.
*/
`timescale 1ns/1ps
`default_nettype none
module scds_top
  import scds_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command port pins
  input wire logic sck,
  input wire logic si,
  input wire logic control_select_n,
  output logic so,
  output logic so_oe,
  // Data port pins
  input wire logic sync_select_pin,
  input wire logic data_bit_clock,
  input wire logic data_serial_in,
  output logic data_request,
  output logic [1:0] gpio_in,
  // Received bytes toward the decoder
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  input wire logic [9:0] fifo_free,
  // Register access toward the core
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic core_busy,
  // Mode register contents
  output logic [15:0] mode
);
  logic [SCDS_PINS-1:0] pins; // Raw pin levels
  logic [SCDS_PINS-1:0] s1_q; // First sync stage
  logic [SCDS_PINS-1:0] s2_q; // Second sync stage
  logic [SCDS_PINS-1:0] s3_q; // Third sync stage
  logic [SCDS_PINS-1:0] f_q; // Agreed pin level
  logic [SCDS_PINS-1:0] fp_q; // Agreed level one cycle ago
  logic sck_rise; // Command clock rising
  logic sck_fall; // Command clock falling
  logic cs_n; // Control select, filtered
  logic [15:0] mode_q; // Mode register
  scds_cmd_t cmd_st_q; // Command port state
  logic [3:0] cnt_q; // Command bit counter
  logic [15:0] hdr_q; // Instruction and address shifter
  logic [15:0] wsh_q; // Write word shifter
  logic [15:0] rsh_q; // Read word shifter
  logic rd_ld_q; // Read word loaded
  logic [15:0] hdr_n; // Header with current bit
  logic [15:0] wsh_n; // Word with current bit
  logic [15:0] rd_val; // Word to read back
  logic so_q; // Serial output bit
  logic so_oe_q; // Serial output enable
  logic wr_q; // Register write pulse
  logic [7:0] addr_q; // Register address
  logic [15:0] wd_q; // Register write data
  logic [3:0] low_q; // Data request hold-off count
  logic data_request_q; // Data request
  logic [9:0] area; // Active safety area
  logic native; // Native pin use
  logic passive; // Passive data mode
  logic dsel_n; // Data select, effective
  logic d_clk; // Data clock level, effective
  logic d_clk_p; // Data clock level, previous
  logic d_edge; // Active data clock edge
  logic d_bit; // Data input bit
  logic bs; // Byte sync level
  logic [2:0] dcnt_q; // Data bit counter
  logic dact_q; // Compatibility receiver active
  logic bsp_q; // Byte sync at previous edge
  logic [7:0] dsh_q; // Data byte shifter
  logic [7:0] dsh_n; // Data byte with current bit
  logic push_q; // Byte offered to buffer
  logic [7:0] byte_q; // Byte value offered
  logic [1:0] gpio_q; // Repurposed pin levels

  scds_stream_if in_if ();
  scds_stream_if out_if ();

  // Two-entry buffer in the byte path
  scds_buf u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_s(in_if.snk),
    .out_s(out_if.src)
  );

  assign in_if.valid = push_q;
  assign in_if.data = byte_q;
  assign out_if.ready = out_ready;
  assign out_valid = out_if.valid;
  assign out_data = out_if.data;

  assign pins = {data_serial_in, data_bit_clock, sync_select_pin,
                 control_select_n, si, sck};

  // Three-stage synchroniser; level changes once stages two and three agree
  for (genvar i = 0; i < SCDS_PINS; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        s1_q[i] <= SCDS_PIN_IDLE[i];
        s2_q[i] <= SCDS_PIN_IDLE[i];
        s3_q[i] <= SCDS_PIN_IDLE[i];
        f_q[i] <= SCDS_PIN_IDLE[i];
        fp_q[i] <= SCDS_PIN_IDLE[i];
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          f_q[i] <= s3_q[i];
        end
        fp_q[i] <= f_q[i];
      end
    end
  end

  assign sck_rise = f_q[SCDS_PIN_SCK] & ~fp_q[SCDS_PIN_SCK];
  assign sck_fall = ~f_q[SCDS_PIN_SCK] & fp_q[SCDS_PIN_SCK];
  assign cs_n = f_q[SCDS_PIN_CS];

  // Mode decode
  assign native = mode_q[SCDS_BIT_NATIVE_PIN];
  assign passive = ~mode_q[SCDS_BIT_NEWMODE] & mode_q[SCDS_BIT_SHARED]
                   & ~native;
  assign area = mode_q[SCDS_BIT_LARGE_AREA] ? SCDS_AREA_LARGE
                : SCDS_AREA_SMALL;
  assign dsel_n = mode_q[SCDS_BIT_SHARED] ? ~cs_n
                  : f_q[SCDS_PIN_SYNC];
  assign bs = f_q[SCDS_PIN_SYNC];

  // Effective data clock and active edge
  assign d_clk = native ? f_q[SCDS_PIN_SCK] : f_q[SCDS_PIN_DATA_BIT_CLOCK];
  assign d_clk_p = native ? fp_q[SCDS_PIN_SCK] : fp_q[SCDS_PIN_DATA_BIT_CLOCK];
  assign d_edge = mode_q[SCDS_BIT_FALLING] ? (~d_clk & d_clk_p)
                  : (d_clk & ~d_clk_p);
  assign d_bit = native ? f_q[SCDS_PIN_SI] : f_q[SCDS_PIN_DATA_SERIAL_IN];
  assign dsh_n = mode_q[SCDS_BIT_LSB_FIRST] ? {d_bit, dsh_q[7:1]}
                 : {dsh_q[6:0], d_bit};

  // Command shifters with the incoming bit
  assign hdr_n = {hdr_q[14:0], f_q[SCDS_PIN_SI]};
  assign wsh_n = {wsh_q[14:0], f_q[SCDS_PIN_SI]};
  assign rd_val = (addr_q == SCDS_MODE_ADDR) ? mode_q : reg_rdata;

  // Command port frame state machine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_st_q <= SCDS_C_HDR;
      cnt_q <= 4'h0;
      hdr_q <= 16'h0000;
      wsh_q <= 16'h0000;
    end else if (cs_n) begin
      // Standby: drop partial frame, restart at bit one
      cmd_st_q <= SCDS_C_HDR;
      cnt_q <= 4'h0;
    end else if (sck_rise) begin
      // Rising edge with select low samples input
      cnt_q <= cnt_q + 4'h1;
      case (cmd_st_q)
        SCDS_C_HDR: begin
          hdr_q <= hdr_n;
          if (cnt_q == 4'hf) begin
            // Only the two opcodes are acted on
            if (hdr_n[15:8] == SCDS_INSTR_READ) begin
              cmd_st_q <= SCDS_C_RD;
            end else if (hdr_n[15:8] == SCDS_INSTR_WRITE) begin
              cmd_st_q <= SCDS_C_WR;
            end else begin
              cmd_st_q <= SCDS_C_SKIP;
            end
          end
        end
        SCDS_C_WR: begin
          // Counter wraps, so further words hit the same register
          wsh_q <= wsh_n;
        end
        SCDS_C_RD: begin
          // Input ignored after the address
          cmd_st_q <= SCDS_C_RD;
        end
        default: begin
          cmd_st_q <= SCDS_C_SKIP;
        end
      endcase
    end
  end

  // Register address capture and write commit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_q <= 8'h00;
      wd_q <= 16'h0000;
      wr_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (!cs_n && sck_rise && cmd_st_q == SCDS_C_HDR && cnt_q == 4'hf) begin
        addr_q <= hdr_n[7:0];
      end
      // Commit only on a complete word
      if (!cs_n && sck_rise && cmd_st_q == SCDS_C_WR && cnt_q == 4'hf) begin
        wd_q <= wsh_n;
        wr_q <= 1'b1;
      end
    end
  end

  // Mode register, written through the command port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= SCDS_MODE_RESET;
    end else if (wr_q && addr_q == SCDS_MODE_ADDR) begin
      mode_q <= wd_q;
    end
  end

  // Serial output: loads then shifts on falling clock during reads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      rsh_q <= 16'h0000;
      rd_ld_q <= 1'b0;
    end else if (cs_n || cmd_st_q != SCDS_C_RD) begin
      // Released in standby and in writes
      so_oe_q <= 1'b0;
      rd_ld_q <= 1'b0;
    end else if (sck_fall) begin
      so_oe_q <= 1'b1;
      if (!rd_ld_q) begin
        so_q <= rd_val[15];
        rsh_q <= {rd_val[14:0], 1'b0};
        rd_ld_q <= 1'b1;
      end else begin
        so_q <= rsh_q[15];
        rsh_q <= {rsh_q[14:0], 1'b0};
      end
    end
  end

  // Data request hold-off after each command operation
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_q <= 4'h0;
      data_request_q <= 1'b0;
    end else begin
      if (!cs_n && sck_rise && cnt_q == 4'hf && cmd_st_q == SCDS_C_WR) begin
        low_q <= SCDS_WR_LOW_CYC;
      end else if (!cs_n && sck_rise && cnt_q == 4'hf &&
                   cmd_st_q == SCDS_C_RD) begin
        low_q <= SCDS_RD_LOW_CYC;
      end else if (low_q != 4'h0) begin
        low_q <= low_q - 4'h1;
      end
      // High only with room for a full safety area
      data_request_q <= (fifo_free >= area) && in_if.ready && (low_q == 4'h0)
                && !core_busy;
    end
  end

  // Data port byte receiver
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dcnt_q <= 3'h0;
      dact_q <= 1'b0;
      bsp_q <= 1'b0;
      dsh_q <= 8'h00;
      push_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      push_q <= 1'b0;
      if (native) begin
        if (dsel_n) begin
          // Select high realigns bytes
          dcnt_q <= 3'h0;
        end else if (d_edge) begin
          dsh_q <= dsh_n;
          dcnt_q <= dcnt_q + 3'h1;
          if (dcnt_q == 3'h7) begin
            push_q <= 1'b1;
            byte_q <= dsh_n;
          end
        end
      end else if (d_edge) begin
        bsp_q <= bs;
        if (passive) begin
          // Bits only while sync high; sync rise restarts byte
          if (bs) begin
            dsh_q <= dsh_n;
            dcnt_q <= bsp_q ? dcnt_q + 3'h1 : 3'h1;
            if (bsp_q && dcnt_q == 3'h7) begin
              push_q <= 1'b1;
              byte_q <= dsh_n;
            end
          end
        end else if (dact_q || bs) begin
          // Sync high at an idle edge is bit one
          dsh_q <= dsh_n;
          dcnt_q <= dcnt_q + 3'h1;
          if (dcnt_q == 3'h7) begin
            push_q <= 1'b1;
            byte_q <= dsh_n;
            dact_q <= bs;
          end else begin
            dact_q <= 1'b1;
          end
        end
      end
    end
  end

  // Repurposed pins read back as general inputs in native mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_q <= 2'b00;
    end else begin
      gpio_q <= native ? {f_q[SCDS_PIN_DATA_SERIAL_IN], f_q[SCDS_PIN_DATA_BIT_CLOCK]}
                : 2'b00;
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign data_request = data_request_q;
  assign gpio_in = gpio_q;
  assign reg_wr = wr_q;
  assign reg_addr = addr_q;
  assign reg_wdata = wd_q;
  assign mode = mode_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  so_release_a: assert property (cs_n |=> !so_oe_q)
    else $error("serial output driven while deselected");
  so_read_only_a: assert property (
    so_oe_q |-> $past(cmd_st_q) == SCDS_C_RD)
    else $error("serial output driven outside a read");
  wr_complete_a: assert property (
    wr_q |-> $past(cmd_st_q == SCDS_C_WR && cnt_q == 4'hf && !cs_n))
    else $error("register written without full word");
  wr_holdoff_a: assert property (wr_q |=> !data_request_q [*8])
    else $error("data request high during update");
  data_request_room_a: assert property (
    data_request_q |-> $past(fifo_free >= area && low_q == 4'h0))
    else $error("data request without room");
  byte_count_a: assert property (push_q |-> $past(dcnt_q) == 3'h7)
    else $error("byte pushed before eight bits");
  passive_gate_a: assert property (
    !native && passive && d_edge && !bs |=> $stable(dcnt_q))
    else $error("passive mode took a bit without sync");
  native_align_a: assert property (
    native && dsel_n |=> dcnt_q == 3'h0)
    else $error("native byte not realigned by select");
  op_code_a: assert property (
    $rose(cmd_st_q == SCDS_C_WR) |-> $past(hdr_n[15:8]) == SCDS_INSTR_WRITE)
    else $error("write entered without write opcode");

  wr_seen_c: cover property (wr_q);
  rd_seen_c: cover property ($rose(so_oe_q));
  compat_byte_c: cover property (!native && push_q);
  stall_c: cover property (!in_if.ready && data_request_q == 1'b0);
endmodule : scds_top
`default_nettype wire

//--- dv/scds_host_model.sv
/*
  Host model for the serial command and data slave: drives the command
  pins and the data port pins, reads back the serial output.
  Assumes a shared 40 MHz reference clock; pins change on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module scds_host_model (
  // Pacing clock
  input wire logic sys_clk,
  // Command port pins
  output logic sck,
  output logic si,
  output logic control_select_n,
  input wire logic so,
  input wire logic so_oe,
  // Data port pins
  output logic sync_select_pin,
  output logic data_bit_clock,
  output logic data_serial_in,
  input wire logic data_request
);
  int unsigned half_cmd = 8; // Command clock half period in cycles
  int unsigned half_dat = 4; // Data clock half period, 200 ns period
  int unsigned data_request_waits; // Waits that ran out

  // Idle levels: clocks still, selects inactive
  initial begin
    sck = 1'b0;
    si = 1'b1;
    control_select_n = 1'b1;
    sync_select_pin = 1'b1;
    data_bit_clock = 1'b0;
    data_serial_in = 1'b1;
    data_request_waits = 0;
  end

  // Let n falling edges of the reference clock pass
  task automatic gap(input int unsigned n);
    repeat (n) @(negedge sys_clk);
  endtask : gap

  // No new operation until data request is high again
  task automatic wait_data_request();
    int unsigned n;
    n = 0;
    while (data_request !== 1'b1 && n < 400) begin
      gap(1);
      n++;
    end
    if (n >= 400) data_request_waits++;
  endtask : wait_data_request

  // One command bit: input changes on the falling clock edge
  task automatic cmd_bit(input logic b, output logic sob);
    si = b;
    gap(half_cmd);
    sck = ~sck;
    gap(half_cmd);
    sob = so_oe ? so : ~so;
    sck = ~sck;
  endtask : cmd_bit

  // Sends nbits of bits, MSB first; first opens the select
  task automatic cmd_frame(input logic [31:0] bits, input int nbits,
                           input bit first, input bit keep,
                           output logic [15:0] rd);
    logic sob;
    rd = 16'h0000;
    wait_data_request();
    if (first) begin
      control_select_n = 1'b0;
      gap(half_cmd);
    end
    for (int i = nbits - 1; i >= 0; i--) begin
      cmd_bit(bits[i], sob);
      if (i < 16) rd[i] = sob;
    end
    if (!keep) begin
      gap(half_cmd);
      control_select_n = 1'b1;
      // Released input shows the inverse of its last value
      si = ~si;
      gap(half_cmd);
    end
  endtask : cmd_frame

  // One data byte; the host makes the data clock
  // Up to 32 bytes go without checking data request
  // A started byte always runs to its end
  task automatic data_bits(input logic [7:0] b, input bit lsb,
                           input bit native, input bit first,
                           input bit hold);
    for (int k = 0; k < 8; k++) begin
      logic d;
      d = lsb ? b[k] : b[7 - k];
      if (native) begin
        // Select stable for the whole byte; hold keeps the pin high
        // to show the shared flag ignores it
        sync_select_pin = hold;
        si = d;
      end else begin
        // Sync marks bit one, or is held to continue
        sync_select_pin = (k == 0 && first) || hold;
        data_serial_in = d;
      end
      // Data settles a quarter period away from either clock edge
      gap(half_dat / 2);
      if (native) sck = ~sck;
      else data_bit_clock = ~data_bit_clock;
      gap(half_dat);
      if (native) sck = ~sck;
      else data_bit_clock = ~data_bit_clock;
      gap(half_dat / 2);
    end
    // Data line released: inverse of last value
    data_serial_in = ~data_serial_in;
    if (native) sync_select_pin = 1'b1;
    // Released levels stand before the next byte begins
    gap(half_dat);
  endtask : data_bits
endmodule : scds_host_model
`default_nettype wire

//--- dv/tb_top.sv
/*
  Self-checking bench for the serial command and data slave.
  Assumes the host model drives all pins and the bench plays the core.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scds_pkg::*;
  logic sys_clk = 1'b0; // 40 MHz clock
  logic rst = 1'b1; // Synchronous reset
  logic sck, si, control_select_n, so, so_oe;
  logic sync_select_pin, data_bit_clock, data_serial_in, data_request;
  logic [1:0] gpio_in;
  logic out_valid, out_ready, reg_wr, core_busy;
  logic [7:0] out_data, reg_addr;
  logic [9:0] fifo_free;
  logic [15:0] reg_wdata, reg_rdata, mode, rd;
  int unsigned failures, checks_done, wr_count, low_run, last_low;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic oe_seen;
  logic [7:0] got[$]; // Bytes taken from the output side

  scds_top uut (.sys_clk(sys_clk), .rst(rst), .sck(sck), .si(si),
    .control_select_n(control_select_n), .so(so), .so_oe(so_oe),
    .sync_select_pin(sync_select_pin), .data_bit_clock(data_bit_clock),
    .data_serial_in(data_serial_in), .data_request(data_request),
    .gpio_in(gpio_in), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .fifo_free(fifo_free), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .core_busy(core_busy), .mode(mode));
  scds_host_model host (.sys_clk(sys_clk), .sck(sck), .si(si),
    .control_select_n(control_select_n), .so(so), .so_oe(so_oe),
    .sync_select_pin(sync_select_pin), .data_bit_clock(data_bit_clock),
    .data_serial_in(data_serial_in), .data_request(data_request));

  // Clock generator
  always #12.5 sys_clk = ~sys_clk;

  // Core stand-in: each address reads back as itself and its inverse
  assign reg_rdata = {reg_addr, ~reg_addr};

  // Observer: register writes, output enable, low spans, taken bytes
  always @(posedge sys_clk) begin
    if (reg_wr === 1'b1) begin
      wr_count++;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
    end
    if (so_oe === 1'b1) oe_seen = 1'b1;
    if (data_request === 1'b0) low_run++;
    else begin
      if (low_run != 0) last_low = low_run;
      low_run = 0;
    end
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
  end

  // Compare seen against expected and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Print counts and the verdict, then stop
  task automatic give_verdict();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Write the mode register and confirm its contents
  task automatic set_mode(input logic [15:0] v);
    host.cmd_frame({SCDS_INSTR_WRITE, SCDS_MODE_ADDR, v}, 32, 1, 0, rd);
    host.wait_data_request();
    check(mode, v);
  endtask : set_mode

  // Reset state and idle levels
  task automatic t_reset();
    check(mode, SCDS_MODE_RESET);
    check(so_oe, 1'b0);
    check(data_request, 1'b1);
    check(gpio_in, 2'b10);
  endtask : t_reset

  // Single and multiple writes, read, abort, unknown opcode
  task automatic t_command();
    wr_count = 0;
    oe_seen = 1'b0;
    host.cmd_frame({SCDS_INSTR_WRITE, 8'h42, 16'ha5c3}, 32, 1, 0, rd);
    host.wait_data_request();
    host.gap(1);
    check(wr_count, 1);
    check({wr_addr, 8'h00}, 16'h4200);
    check(wr_data, 16'ha5c3);
    check(oe_seen, 1'b0);
    check(last_low >= SCDS_WR_LOW_CYC, 1'b1);
    host.cmd_frame({SCDS_INSTR_WRITE, 8'h43, 16'h1111}, 32, 1, 1, rd);
    host.cmd_frame({16'h0000, 16'h2222}, 16, 0, 0, rd);
    host.wait_data_request();
    check(wr_count, 3);
    check({wr_addr, 8'h00}, 16'h4300);
    check(wr_data, 16'h2222);
    host.cmd_frame({SCDS_INSTR_READ, 8'h11, 16'hffff}, 32, 1, 0, rd);
    check(rd, 16'h11ee);
    check(oe_seen, 1'b1);
    check(so_oe, 1'b0);
    host.wait_data_request();
    check(last_low >= SCDS_RD_LOW_CYC, 1'b1);
    host.cmd_frame({SCDS_INSTR_READ, SCDS_MODE_ADDR, 16'h0000}, 32, 1, 0,
                   rd);
    check(rd, SCDS_MODE_RESET);
    host.cmd_frame({12'h000, SCDS_INSTR_WRITE, 8'h44, 4'h7}, 20, 1, 0, rd);
    host.cmd_frame({8'h01, 8'h45, 16'h3333}, 32, 1, 0, rd);
    host.wait_data_request();
    check(wr_count, 3);
  endtask : t_command

  // Byte reception in native, compatibility and passive modes
  task automatic t_data();
    got.delete();
    host.data_bits(8'h96, 0, 1, 1, 0);
    set_mode(16'h0035);
    host.data_bits(8'h3c, 1, 1, 1, 0);
    set_mode(16'h0007);
    host.data_bits(8'h6b, 0, 1, 1, 1);
    set_mode(16'h0000);
    check(gpio_in, 2'b00);
    host.data_bits(8'ha1, 0, 0, 1, 1);
    host.data_bits(8'h5e, 0, 0, 0, 0);
    set_mode(16'h0002);
    host.data_bits(8'hc7, 0, 0, 1, 1);
    host.data_bits(8'hff, 0, 0, 0, 0);
    host.data_bits(8'h29, 0, 0, 1, 1);
    host.gap(8);
    check(got.size(), 7);
    check(got[0], 8'h96);
    check(got[1], 8'h3c);
    check(got[2], 8'h6b);
    check(got[3], 8'ha1);
    check(got[4], 8'h5e);
    check(got[5], 8'hc7);
    check(got[6], 8'h29);
  endtask : t_data

  // Data request thresholds and the two-entry buffer under a stall
  task automatic t_request();
    set_mode(SCDS_MODE_RESET);
    fifo_free = 10'd31;
    host.gap(4);
    check(data_request, 1'b0);
    fifo_free = 10'd32;
    core_busy = 1'b1;
    host.gap(4);
    check(data_request, 1'b0);
    core_busy = 1'b0;
    host.gap(4);
    check(data_request, 1'b1);
    // Large area: request stays low, so no wait for it here
    host.cmd_frame({SCDS_INSTR_WRITE, SCDS_MODE_ADDR, 16'h000d}, 32, 1, 0,
                   rd);
    check(mode, 16'h000d);
    check(data_request, 1'b0);
    fifo_free = 10'h200;
    host.gap(4);
    check(data_request, 1'b1);
    set_mode(SCDS_MODE_RESET);
    got.delete();
    out_ready = 1'b0;
    host.data_bits(8'h5a, 0, 1, 1, 0);
    host.data_bits(8'h81, 0, 1, 1, 0);
    host.gap(8);
    check(data_request, 1'b0);
    check({out_valid, out_data}, 9'h15a);
    out_ready = 1'b1;
    host.gap(6);
    check(got.size(), 2);
    check({got[0], got[1]}, 16'h5a81);
    check(out_valid, 1'b0);
  endtask : t_request

  // Watchdog
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end

  // Main sequence
  initial begin
    failures = 0;
    checks_done = 0;
    wr_count = 0;
    low_run = 0;
    last_low = 0;
    oe_seen = 1'b0;
    out_ready = 1'b1;
    fifo_free = 10'd100;
    core_busy = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    host.gap(8);
    t_reset();
    t_command();
    t_data();
    t_request();
    check(host.data_request_waits, 0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
